// *** snv_core.sv ***
// Module: serial command decoder, status register and power control
`timescale 1ns/1ps
`default_nettype none
module snv_core #(
  parameter int FIFO_DEPTH = snv_pkg::FIFO_DEPTH
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_cs_n,
  input  wire logic       i_sck,
  input  wire logic       i_si,
  input  wire logic       i_wp_n,
  output logic            o_so,
  output logic            o_so_oe_n,
  output logic            o_regulator_on,
  output logic            o_deep_sleep,
  output logic [7:0]      o_status
);
  localparam int AW = snv_pkg::ADDR_W;

  if (snv_pkg::WAKE_RECOVERY_CYC >= (1 << snv_pkg::PW_CNT_W))
  begin : g_bad_cnt
    $error("Power counter too narrow");
  end

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [3:0] sync1_r, sync2_r;
  logic       sck_d_r, cs_d_r;
  logic       cs_n_s, sck_s, si_s, wp_n_s;
  logic       frame, rise, fall, cs_rise;

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sync1_r <= 4'h9;
      sync2_r <= 4'h9;
      sck_d_r <= 1'b0;
      cs_d_r  <= 1'b1;
    end
    else
    begin
      sync1_r <= {i_cs_n, i_sck, i_si, i_wp_n};
      sync2_r <= sync1_r;
      sck_d_r <= sync2_r[2];
      cs_d_r  <= sync2_r[3];
    end
  end

  assign cs_n_s  = sync2_r[3];
  assign sck_s   = sync2_r[2];
  assign si_s    = sync2_r[1];
  assign wp_n_s  = sync2_r[0];
  assign frame   = ~cs_n_s;
  assign rise    = frame & sck_s & ~sck_d_r;  // R25
  assign fall    = frame & ~sck_s & sck_d_r;  // R25
  assign cs_rise = cs_n_s & ~cs_d_r;

  // ****************************************
  // Frame decoder state
  // ****************************************
  snv_pkg::snv_frame_e  fst_r, fst_nxt;
  snv_pkg::snv_power_e  pst_r, pst_nxt;
  logic [7:0]           opc_r, opc_nxt;
  logic [7:0]           ish_r, ish_nxt;
  logic [7:0]           osh_r, osh_nxt;
  logic [2:0]           bit_r, bit_nxt;
  logic [1:0]           abyte_r, abyte_nxt;
  logic [AW-1:0]        addr_r, addr_nxt;
  logic [7:0]           stat_r, stat_nxt;
  logic                 so_r, so_nxt;
  logic                 oe_n_r, oe_n_nxt;
  logic                 lone_r, lone_nxt;
  logic                 rdq_r, rdq_nxt;
  logic                 load_r;
  logic                 pend_r, pend_nxt;
  snv_pkg::snv_wr_s     wrw_r, wrw_nxt;
  logic [snv_pkg::PW_CNT_W-1:0] pcnt_r, pcnt_nxt;

  logic [7:0]           in_byte;
  logic                 byte_done;
  logic                 driving;
  logic                 write_enable_latch, stat_ok;
  logic                 fifo_rdy, fifo_vld;
  snv_pkg::snv_wr_s     fifo_out;
  logic [7:0]           mem_rdata;
  logic                 mem_wr;

  assign in_byte   = {ish_r[6:0], si_s};
  assign byte_done = rise & (bit_r == 3'h7);
  assign write_enable_latch       = stat_r[snv_pkg::SR_WEL_BIT];
  assign stat_ok   = write_enable_latch & ~(stat_r[snv_pkg::SR_LOCK_BIT] & ~wp_n_s);  // R04 R06 R07
  assign driving   = (fst_r == snv_pkg::FR_DATA)
                   & ((opc_r == snv_pkg::OP_READ) | (opc_r == snv_pkg::OP_RD_STAT));

  always_comb
  begin
    fst_nxt   = fst_r;
    pst_nxt   = pst_r;
    opc_nxt   = opc_r;
    ish_nxt   = ish_r;
    osh_nxt   = osh_r;
    bit_nxt   = bit_r;
    abyte_nxt = abyte_r;
    addr_nxt  = addr_r;
    stat_nxt  = stat_r;
    so_nxt    = so_r;
    oe_n_nxt  = oe_n_r;
    lone_nxt  = lone_r;
    rdq_nxt   = 1'b0;
    pend_nxt  = pend_r & ~fifo_rdy;
    wrw_nxt   = wrw_r;
    pcnt_nxt  = pcnt_r + 1'b1;

    // Power sequencing
    case (pst_r)
      snv_pkg::PW_ENTERING:
        if (pcnt_r == snv_pkg::PW_CNT_W'(snv_pkg::SLEEP_ENTRY_CYC - 1))
          pst_nxt = snv_pkg::PW_SLEEP;  // R21
      snv_pkg::PW_WAKING:
        if (pcnt_r == snv_pkg::PW_CNT_W'(snv_pkg::WAKE_RECOVERY_CYC - 1))
          pst_nxt = snv_pkg::PW_ON;  // R22
      default:
        pcnt_nxt = '0;
    endcase

    // Serial shift-in
    if (rise)
    begin
      ish_nxt = in_byte;
      bit_nxt = bit_r + 3'h1;
    end

    // Serial shift-out on falling edge
    if (fall & driving)
    begin
      so_nxt   = osh_r[7];  // R18
      osh_nxt  = {osh_r[6:0], 1'b0};
      oe_n_nxt = 1'b0;  // R28
    end

    // Read data arrives one cycle after the fetch
    if (load_r)
    begin
      osh_nxt  = mem_rdata;
      addr_nxt = addr_r + 1'b1;  // R17
    end

    if (byte_done)
    begin
      case (fst_r)
        snv_pkg::FR_OPCODE:
        begin
          opc_nxt  = in_byte;
          fst_nxt  = snv_pkg::FR_IGNORE;
          lone_nxt = 1'b0;
          if (pst_r == snv_pkg::PW_ON)
          begin
            case (in_byte)  // R23
              snv_pkg::OP_READ, snv_pkg::OP_WRITE:
              begin
                fst_nxt   = snv_pkg::FR_ADDR;
                abyte_nxt = 2'h0;
              end
              snv_pkg::OP_RD_STAT:
              begin
                fst_nxt = snv_pkg::FR_DATA;
                osh_nxt = stat_r;  // R08
              end
              snv_pkg::OP_WR_STAT:
                fst_nxt = snv_pkg::FR_DATA;
              snv_pkg::OP_SET_WE, snv_pkg::OP_CLR_WE, snv_pkg::OP_SLEEP:
                lone_nxt = 1'b1;
              default:
                lone_nxt = 1'b0;
            endcase
          end
          else if (in_byte == snv_pkg::OP_WAKE && pst_r != snv_pkg::PW_WAKING)
            lone_nxt = 1'b1;
        end
        snv_pkg::FR_ADDR:
        begin
          addr_nxt  = {addr_r[AW-9:0], in_byte};  // R16
          abyte_nxt = abyte_r + 2'h1;
          if (abyte_r == 2'(snv_pkg::ADDR_BYTES - 1))
          begin
            fst_nxt = snv_pkg::FR_DATA;
            rdq_nxt = (opc_r == snv_pkg::OP_READ);
          end
        end
        snv_pkg::FR_DATA:
        begin
          case (opc_r)
            snv_pkg::OP_READ:
              rdq_nxt = 1'b1;  // R17
            snv_pkg::OP_RD_STAT:
              osh_nxt = stat_r;
            snv_pkg::OP_WRITE:
            begin
              addr_nxt = addr_r + 1'b1;  // R19
              if (write_enable_latch & ~snv_pkg::snv_blocked(stat_r[3:2], addr_r))  // R04 R05 R27
              begin
                pend_nxt = 1'b1;
                wrw_nxt  = '{addr: addr_r, data: in_byte};
              end
            end
            snv_pkg::OP_WR_STAT:
            begin
              fst_nxt = snv_pkg::FR_IGNORE;
              if (stat_ok)  // R14
                stat_nxt = {in_byte[7:2], stat_r[1], in_byte[0]};  // R02 R06 R07
            end
            default:
              fst_nxt = snv_pkg::FR_IGNORE;
          endcase
        end
        default:
          lone_nxt = 1'b0;
      endcase
    end
    else if (rise & (fst_r == snv_pkg::FR_IGNORE))
      lone_nxt = 1'b0;  // R24

    // End of frame: lone opcodes take effect here
    if (cs_rise)
    begin
      fst_nxt  = snv_pkg::FR_OPCODE;
      bit_nxt  = 3'h0;
      oe_n_nxt = 1'b1;  // R28
      so_nxt   = 1'b0;
      lone_nxt = 1'b0;
      if (lone_r & (bit_r == 3'h0))  // R12 R24
      begin
        case (opc_r)
          snv_pkg::OP_SET_WE:
            stat_nxt[snv_pkg::SR_WEL_BIT] = 1'b1;  // R09
          snv_pkg::OP_CLR_WE:
            stat_nxt[snv_pkg::SR_WEL_BIT] = 1'b0;  // R10 R11
          snv_pkg::OP_SLEEP:
          begin
            pst_nxt  = snv_pkg::PW_ENTERING;  // R21
            pcnt_nxt = '0;
          end
          snv_pkg::OP_WAKE:
          begin
            pst_nxt  = snv_pkg::PW_WAKING;  // R22
            pcnt_nxt = '0;
          end
          default:
            lone_nxt = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      fst_r   <= snv_pkg::FR_OPCODE;
      pst_r   <= snv_pkg::PW_ON;
      opc_r   <= 8'h00;
      ish_r   <= 8'h00;
      osh_r   <= 8'h00;
      bit_r   <= 3'h0;
      abyte_r <= 2'h0;
      addr_r  <= '0;
      stat_r  <= snv_pkg::STATUS_RST;  // R03 R11
      so_r    <= 1'b0;
      oe_n_r  <= 1'b1;
      lone_r  <= 1'b0;
      rdq_r   <= 1'b0;
      load_r  <= 1'b0;
      pend_r  <= 1'b0;
      wrw_r   <= '0;
      pcnt_r  <= '0;
    end
    else
    begin
      fst_r   <= fst_nxt;
      pst_r   <= pst_nxt;
      opc_r   <= opc_nxt;
      ish_r   <= ish_nxt;
      osh_r   <= osh_nxt;
      bit_r   <= bit_nxt;
      abyte_r <= abyte_nxt;
      addr_r  <= addr_nxt;
      stat_r  <= stat_nxt;
      so_r    <= so_nxt;
      oe_n_r  <= oe_n_nxt;
      lone_r  <= lone_nxt;
      rdq_r   <= rdq_nxt;
      load_r  <= rdq_r;
      pend_r  <= pend_nxt;
      wrw_r   <= wrw_nxt;
      pcnt_r  <= pcnt_nxt;
    end
  end

  // ****************************************
  // Write buffer and array
  // ****************************************
  // Read fetch owns the array port; queued writes wait a cycle
  assign mem_wr = fifo_vld & ~rdq_r;  // R20

  snv_fifo #(
    .WIDTH ($bits(snv_pkg::snv_wr_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_valid   (pend_r),
    .o_ready   (fifo_rdy),
    .i_data    (wrw_r),
    .o_valid   (fifo_vld),
    .i_ready   (~rdq_r),
    .o_data    (fifo_out)
  );

  snv_mem #(
    .ADDR_W (AW),
    .DEPTH  (snv_pkg::MEM_DEPTH)
  ) u_mem (
    .i_ref_clk (i_ref_clk),
    .i_rd_en   (rdq_r),
    .i_wr_en   (mem_wr),
    .i_addr    (rdq_r ? addr_r : fifo_out.addr),
    .i_wdata   (fifo_out.data),
    .o_rdata   (mem_rdata)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign o_so           = so_r;
  assign o_so_oe_n      = oe_n_r;
  assign o_status       = stat_r;  // R01
  assign o_regulator_on = (pst_r == snv_pkg::PW_ON) | (pst_r == snv_pkg::PW_WAKING);
  assign o_deep_sleep   = (pst_r == snv_pkg::PW_SLEEP);
endmodule
`default_nettype wire

// *** snv_core_chk.sv ***
// Port assertions of the serial memory core
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Checker
// ****************************************
module snv_core_chk (
  input wire logic       i_ref_clk,
  input wire logic       i_rstn,
  input wire logic       i_cs_n,
  input wire logic       i_sck,
  input wire logic       i_si,
  input wire logic       i_wp_n,
  input wire logic       o_so,
  input wire logic       o_so_oe_n,
  input wire logic       o_regulator_on,
  input wire logic       o_deep_sleep,
  input wire logic [7:0] o_status
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  AST_SO_RELEASED: assert property (i_cs_n [*5] |-> o_so_oe_n)
    else $error("serial out driven while deselected");
  AST_SO_IDLE_LOW: assert property (o_so_oe_n |-> !o_so)
    else $error("serial out not low while released");
  AST_SO_IN_FRAME: assert property ($fell(o_so_oe_n) |-> !$past(i_cs_n, 3))
    else $error("serial out enabled outside a frame");
  AST_STATUS_IDLE: assert property (i_cs_n [*6] |=> $stable(o_status))
    else $error("status changed with no command");
  AST_LATCH_AT_END: assert property ($changed(o_status[1]) |-> i_cs_n)
    else $error("write latch changed inside a frame");
  AST_LOCK_FREEZE: assert property ((o_status[7] && !i_wp_n) [*4] |=> $stable(o_status[7:2]))
    else $error("locked status bits changed");
  AST_SLEEP_ENTRY: assert property ($fell(o_regulator_on) |-> !o_deep_sleep [*8] ##[20:26] o_deep_sleep)
    else $error("deep sleep entry time wrong");
  AST_SLEEP_EXCL: assert property (o_deep_sleep |-> !o_regulator_on)
    else $error("deep sleep with regulator on");
  AST_WAKE: assert property ($rose(o_regulator_on) |-> !o_deep_sleep ##1 o_regulator_on [*8])
    else $error("wake did not hold regulator on");
endmodule

bind snv_core snv_core_chk u_chk (.i_ref_clk, .i_rstn, .i_cs_n, .i_sck, .i_si, .i_wp_n, .o_so,
  .o_so_oe_n, .o_regulator_on, .o_deep_sleep, .o_status);
`default_nettype wire

// *** snv_fifo.sv ***
// Module: write request FIFO between the serial front end and the array
`timescale 1ns/1ps
`default_nettype none
module snv_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 8
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rstn,
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic      [WIDTH-1:0] o_data
);
  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH)
  begin : g_bad_depth
    $error("FIFO depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [PW:0]      cnt_r, cnt_nxt;
  logic             push, pop;

  assign o_ready = (cnt_r != (PW+1)'(DEPTH));
  assign o_valid = (cnt_r != '0);
  assign o_data  = mem_r[rp_r];
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;

  always_comb
  begin
    wp_nxt  = push ? wp_r + 1'b1 : wp_r;
    rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (push)
      mem_r[wp_r] <= i_data;
  end
endmodule
`default_nettype wire

// *** snv_mem.sv ***
// Module: single-port byte array with registered read
`timescale 1ns/1ps
`default_nettype none
module snv_mem #(
  parameter int ADDR_W = 17,
  parameter int DEPTH  = 131072
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_rd_en,
  input  wire logic              i_wr_en,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [7:0]        i_wdata,
  output logic      [7:0]        o_rdata
);
  if (DEPTH > (1 << ADDR_W))
  begin : g_bad_depth
    $error("Array depth exceeds address range");
  end

  logic [7:0] arr_r [DEPTH];

  always_ff @(posedge i_ref_clk)
  begin
    if (i_wr_en)
      arr_r[i_addr] <= i_wdata;
    if (i_rd_en)
      o_rdata <= arr_r[i_addr];
  end
endmodule
`default_nettype wire

// *** snv_pkg.sv ***
// Package: constants, types and helpers of the serial nonvolatile memory core
// Function
// R01: Eight-bit status: lock bit 7, protect-high 3, protect-low 2, write latch 1.
// R02: Status bits 6, 5, 4, 0 are read/write and steer nothing.
// R03: All status bits are zero after power-up.
// R04: Latch clear blocks all writes; set allows unprotected array and unlocked status.
// R05: Protect pair selects none, upper quarter, upper half or whole array.
// R06: Lock set and protect pin low freeze the protect bits until pin high.
// R07: Protect pin high means software mode, protect bits writable by status write.
// R08: Status read works any time; bit 0 is never set by internal writes. Core decodes status read only while powered on.
// R09: Set-latch command sets the write latch; host sends it before each write.
// R10: Clear-latch command clears the latch, refusing later status and array writes.
// R11: Write latch is clear at power-up and after a clear-latch command.
// R12: Host sends latch, sleep and wake commands as a lone opcode byte.
// R13: Host sends status write as opcode plus exactly one data byte.
// R14: Status write only with latch set and lock/pin permitting; else unchanged.
// R15: Host rewrites status after each power cycle unless written right after power-up.
// R16: Read and write take three address bytes; only bits 16 to 0 count.
// R17: Read streams incrementing addresses, wrapping from top to zero.
// R18: Read data leaves on serial out after the address until select rises.
// R19: Write stores each byte at incrementing addresses, wrapping to zero.
// R20: Array writes run at full clock rate with no busy time between commands.
// R21: Sleep turns regulators off; deep standby after the entry time past select rise.
// R22: Wake turns regulators on; ready after recovery time; host holds select high.
// R23: Opcodes 06, 04, 05, 01, 03, 02, B9, AB hex; read and write carry addresses.
// R24: One command per select low period; host ends it on a byte boundary.
// R25: Serial in sampled on rising clock, serial out changed on falling, modes 0 and 3.
// R26: Host waits at least 400 us after wake before selecting again.
// R27: Refused or protected writes are taken on the bus and silently dropped.
// R28: Serial out stays released except while shifting status or read data.
package snv_pkg;

  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 131072;
  localparam int FIFO_DEPTH = 8;
  localparam int ADDR_BYTES = 3;
  localparam int CLK_MHZ = 10;
  localparam int SLEEP_ENTRY_NS = 3000;
  localparam int WAKE_RECOVERY_US = 400;
  localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_RECOVERY_CYC = WAKE_RECOVERY_US * CLK_MHZ;
  localparam int PW_CNT_W = 12;

  localparam logic [7:0] OP_SET_WE = 8'h06;
  localparam logic [7:0] OP_CLR_WE = 8'h04;
  localparam logic [7:0] OP_RD_STAT = 8'h05;
  localparam logic [7:0] OP_WR_STAT = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_SLEEP = 8'hb9;
  localparam logic [7:0] OP_WAKE = 8'hab;

  localparam int SR_LOCK_BIT = 7;
  localparam int SR_BPH_BIT = 3;
  localparam int SR_BPL_BIT = 2;
  localparam int SR_WEL_BIT = 1;
  localparam logic [7:0] STATUS_RST = 8'h00;

  typedef enum logic [1:0]
  {
    FR_OPCODE = 2'b00,
    FR_ADDR   = 2'b01,
    FR_DATA   = 2'b10,
    FR_IGNORE = 2'b11
  } snv_frame_e;

  typedef enum logic [1:0]
  {
    PW_ON       = 2'b00,
    PW_ENTERING = 2'b01,
    PW_SLEEP    = 2'b10,
    PW_WAKING   = 2'b11
  } snv_power_e;

  typedef struct packed
  {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } snv_wr_s;

  // Protected region decode
  function automatic logic snv_blocked(input logic [1:0] bp, input logic [ADDR_W-1:0] addr);
    case (bp)
      2'b00:   snv_blocked = 1'b0;
      2'b01:   snv_blocked = addr[ADDR_W-1] & addr[ADDR_W-2];
      2'b10:   snv_blocked = addr[ADDR_W-1];
      default: snv_blocked = 1'b1;
    endcase
  endfunction

endpackage

// *** snv_spi_host.sv ***
// Serial host model driving chip select, clock and data in
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host model
// ****************************************
module snv_spi_host (
  input  wire logic i_ref_clk,
  input  wire logic i_so,
  input  wire logic i_so_oe_n,
  output var logic  o_cs_n,
  output var logic  o_sck,
  output var logic  o_si
);
  logic m3;
  logic last;

  initial
  begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
    m3 = 1'b0;
    last = 1'b0;
  end

  // Clock idle level picks mode 0 or 3
  task automatic begin_frame(input logic mode3);
    m3 = mode3;
    @(negedge i_ref_clk);
    o_sck = mode3;
    repeat (4) @(negedge i_ref_clk);
    o_cs_n = 1'b0;
    repeat (4) @(negedge i_ref_clk);
  endtask

  // One byte, MSB first, 800 ns per bit
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      @(negedge i_ref_clk);
      o_sck = 1'b0;
      o_si = tx[i];
      repeat (4) @(negedge i_ref_clk);
      o_sck = 1'b1;
      last = (i_so_oe_n === 1'b0) ? i_so : ~last;
      rx[i] = last;
      repeat (3) @(negedge i_ref_clk);
    end
  endtask

  // Deselect only on a byte boundary
  task automatic end_frame();
    @(negedge i_ref_clk);
    if (!m3)
      o_sck = 1'b0;
    repeat (4) @(negedge i_ref_clk);
    o_cs_n = 1'b1;
    o_si = ~o_si;
    repeat (8) @(negedge i_ref_clk);
  endtask
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench of the serial memory core
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Bench
// ****************************************
module testbench;
  logic       ref_clk = 1'b0;
  logic       rstn = 1'b0;
  logic       wp_n = 1'b1;
  logic       cs_n;
  logic       sck;
  logic       si;
  logic       so;
  logic       so_oe_n;
  logic       reg_on;
  logic       deep;
  logic [7:0] status;
  logic [7:0] mem [int];
  int         sr = 0;
  bit         slp = 1'b0;
  int         err_count = 0;
  int         compares = 0;
  int         cyc = 0;

  always #50 ref_clk = ~ref_clk;

  snv_core u_dut (.i_ref_clk(ref_clk), .i_rstn(rstn), .i_cs_n(cs_n), .i_sck(sck), .i_si(si),
    .i_wp_n(wp_n), .o_so(so), .o_so_oe_n(so_oe_n), .o_regulator_on(reg_on),
    .o_deep_sleep(deep), .o_status(status));

  snv_spi_host u_host (.i_ref_clk(ref_clk), .i_so(so), .i_so_oe_n(so_oe_n), .o_cs_n(cs_n),
    .o_sck(sck), .o_si(si));

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic bit blk(input int a);
    case ((sr >> 2) & 3)
      0: return 1'b0;
      1: return a >= 'h18000;
      2: return a >= 'h10000;
      default: return 1'b1;
    endcase
  endfunction

  // One frame on the link with the reference model alongside
  task automatic run(input logic [7:0] op, input int a, input int n, input logic [7:0] d);
    logic [7:0] rx;
    logic [7:0] tx;
    u_host.begin_frame(1'($urandom));
    u_host.xfer(op, rx);
    if (op == 8'h03 || op == 8'h02)
      for (int k = 2; k >= 0; k--)
        u_host.xfer(8'((a | ($urandom & 'h7f) << 17) >> (8 * k)), rx);
    for (int i = 0; i < n; i++)
    begin
      tx = (op == 8'h01) ? d : 8'($urandom);
      u_host.xfer(tx, rx);
      if (!slp)
      begin
        if (op == 8'h05) chk(rx, 8'(sr));
        if (op == 8'h03 && mem.exists(a)) chk(rx, mem[a]);
        if (op == 8'h02 && sr[1] && !blk(a)) mem[a] = tx;
        if (op == 8'h01 && i == 0 && sr[1] && !(sr[7] && !wp_n)) sr = (tx & 'hfd) | (sr & 2);
      end
      a = (a + 1) & 'h1ffff;
    end
    u_host.end_frame();
    if (op == 8'hab && n == 0)
      slp = 1'b0;
    else if (!slp && n == 0)
    begin
      if (op == 8'h06) sr |= 2;
      if (op == 8'h04) sr &= 'hfd;
      if (op == 8'hb9) slp = 1'b1;
    end
    chk(status, 8'(sr));
  endtask

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      err_count++;
      conclude();
    end
  end

  initial
  begin
    void'($urandom(78731));
    repeat (16) @(negedge ref_clk);
    rstn = 1'b1;
    chk({so, so_oe_n, reg_on, deep, 4'h0}, 8'h60);
    chk(status, 8'h00);
    repeat (4) @(negedge ref_clk);
    run(8'h05, 0, 1, 0);
    run(8'h01, 0, 1, 8'hff);
    run(8'h06, 0, 0, 0);
    run(8'h04, 0, 0, 0);
    run(8'h01, 0, 1, 8'hff);
    run(8'h06, 0, 0, 0);
    run(8'h01, 0, 1, 8'h71);
    run(8'h05, 0, 1, 0);
    run(8'h02, 'h1fffe, 3, 0);
    run(8'h02, 'h1fffe, 3, 0);
    run(8'h03, 'h1fffe, 3, 0);
    for (int bp = 0; bp < 4; bp++)
    begin
      run(8'h01, 0, 1, 8'(bp << 2));
      for (int j = 0; j < 3; j++)
      begin
        run(8'h02, 'h8000 * (j + 1), 1, 0);
        run(8'h03, 'h8000 * (j + 1), 1, 0);
      end
    end
    run(8'h01, 0, 1, 8'h8c);
    wp_n = 1'b0;
    run(8'h01, 0, 1, 8'h00);
    wp_n = 1'b1;
    run(8'h01, 0, 1, 8'h00);
    run(8'h04, 0, 0, 0);
    run(8'h02, 'h8000, 1, 0);
    run(8'h03, 'h8000, 1, 0);
    run(8'hb9, 0, 0, 0);
    repeat (40) @(negedge ref_clk);
    chk(8'({reg_on, deep}), 8'h01);
    run(8'h06, 0, 0, 0);
    run(8'hab, 0, 0, 0);
    chk(8'({reg_on, deep}), 8'h02);
    repeat (snv_pkg::WAKE_RECOVERY_CYC) @(negedge ref_clk);
    run(8'h06, 0, 0, 0);
    run(8'h04, 0, 1, 0);
    run(8'h5a, 0, 1, 0);
    run(8'h05, 0, 1, 0);
    conclude();
  end
endmodule
`default_nettype wire
